// *** spe_defines.svh ***
`ifndef SPE_DEFINES_SVH
`define SPE_DEFINES_SVH

// ==========================================================
// Entry key and configuration constants
// ==========================================================
// Number of bits in the low-voltage entry key.
`define SPE_KEY_BITS 32
// Width of the key bit counter.
`define SPE_CNT_W 6
// Key value compared on entry; this value is arbitrary.
`define SPE_KEY_VALUE 32'h5A3C_96E1
// Shift order of the key: 1 means first bit is the most significant.
`define SPE_KEY_MSB_FIRST 1'b1
// Configuration value that enables the low-voltage entry path.
`define SPE_LV_ENABLE_ON 1'b1
// Number of synchronised pin levels.
`define SPE_PIN_W 4

`endif

// *** spe_pkg.sv ***
package spe_pkg;

    // ==========================================================
    // Mode states
    // ==========================================================
    typedef enum logic [2:0] {
        SPE_NORMAL,
        SPE_KEY_SHIFT,
        SPE_KEY_REJECT,
        SPE_LV_PROG,
        SPE_HV_PROG,
        SPE_HV_REJECT
    } spe_state_e;

    // ==========================================================
    // Synchronised pin levels
    // ==========================================================
    typedef struct packed {
        logic clk;
        logic dat;
        logic mc_low;
        logic mc_hv;
    } spe_pins_s;

    // ==========================================================
    // Complete state of the entry block
    // ==========================================================
    typedef struct packed {
        spe_state_e state;
        logic [31:0] shift;
        logic [5:0] cnt;
        logic clk_d;
        logic data_out;
        logic data_oe_n;
        logic rx_bit;
        logic rx_stb;
        logic prog_mode;
        logic hv_mode;
        logic lv_mode;
        logic mem_wr_allow;
        logic lv_enable_clr_grant;
        logic clear_rst_en;
        logic core_reset;
    } spe_st_s;

endpackage

// *** spe_sync2.sv ***
`timescale 1ns/1ps

// ==========================================================
// Two-stage synchroniser for asynchronous pin levels
// ==========================================================
module spe_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage, nothing else looks at it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// *** spe_entry.sv ***
// Function
// - HV entry: clock and data held low while master clear reaches high voltage.
// - Low-voltage entry accepted only while the LV enable configuration bit is one.
// - LV entry: master clear low, then 32-bit key shifted in with clock.
// - Program/verify mode held only while master clear stays at its entry level: low for LV entry, high voltage for HV entry.
// - LV enable set forces master clear reset function on, overriding configuration.
// - LV enable bit may be cleared to zero only from high-voltage mode.
// - Clock pin is input only; data pin direction alternates with programmer.
// - In program mode, memory, user IDs and configuration may be written/verified.
`timescale 1ns/1ps
`include "spe_defines.svh"

module spe_entry
    import spe_pkg::*;
#(
    parameter logic [31:0] KEY_VALUE = `SPE_KEY_VALUE,
    parameter logic KEY_MSB_FIRST = `SPE_KEY_MSB_FIRST
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Programming pins, asynchronous to sys_clk.
    input wire logic prog_clock_pin,
    input wire logic prog_data_pin_i,
    output logic prog_data_pin_o,
    output logic prog_data_pin_oe_n,
    // Master clear comparators, asynchronous to sys_clk.
    input wire logic master_clear_low,
    input wire logic master_clear_hv,
    // Configuration word bits, on sys_clk.
    input wire logic low_voltage_prog_enable,
    input wire logic clear_reset_disable_cfg,
    // Serial command engine, on sys_clk.
    input wire logic dev_drive_req,
    input wire logic dev_drive_bit,
    input wire logic lv_enable_clear_req,
    // Mode and stream outputs.
    output logic rx_bit,
    output logic rx_stb,
    output logic prog_mode,
    output logic hv_mode,
    output logic lv_mode,
    output logic mem_wr_allow,
    output logic lv_enable_clr_grant,
    output logic clear_rst_en,
    output logic core_reset
);

    // ==========================================================
    // Functions
    // ==========================================================
    // Inserts one sampled bit into the key register in the chosen order.
    function automatic logic [31:0] key_shift(input logic [31:0] cur, input logic b);
        logic [31:0] res;
        res = cur;
        if (KEY_MSB_FIRST) begin
            res = {cur[30:0], b};
        end else begin
            res = {b, cur[31:1]};
        end
        return res;
    endfunction

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    spe_pins_s pins;
    logic [3:0] pins_raw;
    logic [3:0] pins_sync;

    assign pins_raw = {prog_clock_pin, prog_data_pin_i, master_clear_low, master_clear_hv};
    assign pins = spe_pins_s'(pins_sync);

    spe_sync2 #(
        .W(`SPE_PIN_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // ==========================================================
    // State update
    // ==========================================================
    spe_st_s st_r;
    spe_st_s st_nxt;
    logic clk_rise;
    logic clk_fall;
    logic in_prog;
    logic lv_enable_on;

    assign clk_rise = pins.clk & ~st_r.clk_d;
    assign clk_fall = ~pins.clk & st_r.clk_d;
    assign lv_enable_on = (low_voltage_prog_enable == `SPE_LV_ENABLE_ON);

    // Next-state logic: the whole block state is computed in one place.
    always_comb begin
        st_nxt = st_r;
        in_prog = 1'b0;
        st_nxt.clk_d = pins.clk;
        st_nxt.rx_stb = 1'b0;
        case (st_r.state)
            SPE_NORMAL: begin
                st_nxt.shift = '0;
                st_nxt.cnt = '0;
                // High voltage wins over a low master clear, it is the stronger route.
                if (pins.mc_hv) begin
                    if (~pins.clk & ~pins.dat) begin
                        st_nxt.state = SPE_HV_PROG;
                    end else begin
                        st_nxt.state = SPE_HV_REJECT;
                    end
                end else if (pins.mc_low && lv_enable_on) begin
                    st_nxt.state = SPE_KEY_SHIFT;
                end
            end
            SPE_KEY_SHIFT: begin
                if (!pins.mc_low || !lv_enable_on) begin
                    st_nxt.state = SPE_NORMAL;
                    st_nxt.shift = '0;
                    st_nxt.cnt = '0;
                end else if (st_r.cnt == 6'(`SPE_KEY_BITS)) begin
                    // The full key is in; one comparison, no sliding window.
                    if (st_r.shift == KEY_VALUE) begin
                        st_nxt.state = SPE_LV_PROG;
                    end else begin
                        st_nxt.state = SPE_KEY_REJECT;
                    end
                end else if (clk_fall) begin
                    st_nxt.shift = key_shift(st_r.shift, pins.dat);
                    st_nxt.cnt = st_r.cnt + 6'h01;
                end
            end
            SPE_KEY_REJECT: begin
                // A bad key needs a fresh master clear cycle before a retry.
                st_nxt.shift = '0;
                st_nxt.cnt = '0;
                if (!pins.mc_low) begin
                    st_nxt.state = SPE_NORMAL;
                end
            end
            SPE_LV_PROG: begin
                in_prog = 1'b1;
                if (!pins.mc_low) begin
                    st_nxt.state = SPE_NORMAL;
                    in_prog = 1'b0;
                    st_nxt.shift = '0;
                    st_nxt.cnt = '0;
                end
            end
            SPE_HV_PROG: begin
                in_prog = 1'b1;
                if (!pins.mc_hv) begin
                    st_nxt.state = SPE_NORMAL;
                    in_prog = 1'b0;
                end
            end
            SPE_HV_REJECT: begin
                if (!pins.mc_hv) begin
                    st_nxt.state = SPE_NORMAL;
                end
            end
            default: begin
                st_nxt.state = SPE_NORMAL;
            end
        endcase

        // Mode flags; they drop in the same cycle as the exit decision.
        st_nxt.prog_mode = in_prog;
        st_nxt.hv_mode = in_prog && (st_r.state == SPE_HV_PROG);
        st_nxt.lv_mode = in_prog && (st_r.state == SPE_LV_PROG);
        st_nxt.mem_wr_allow = in_prog;

        // Received bits go to the command engine on each rising clock edge.
        if (in_prog && clk_rise) begin
            st_nxt.rx_bit = pins.dat;
            st_nxt.rx_stb = 1'b1;
        end

        // The data driver is only on in program mode and when asked to drive.
        st_nxt.data_oe_n = ~(in_prog & dev_drive_req);
        st_nxt.data_out = in_prog & dev_drive_req & dev_drive_bit;

        // Clearing the LV enable bit is refused from the low-voltage route.
        st_nxt.lv_enable_clr_grant = lv_enable_clear_req && in_prog
            && (st_r.state == SPE_HV_PROG);

        // The reset disable setting is ignored while LV entry is enabled.
        st_nxt.clear_rst_en = lv_enable_on | ~clear_reset_disable_cfg;
        st_nxt.core_reset = (lv_enable_on | ~clear_reset_disable_cfg) & pins.mc_low
            & ~in_prog;
    end

    // Single register for the whole block state.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '{
                state: SPE_NORMAL,
                shift: 32'h0000_0000,
                cnt: 6'h00,
                clk_d: 1'b0,
                data_out: 1'b0,
                data_oe_n: 1'b1,
                rx_bit: 1'b0,
                rx_stb: 1'b0,
                prog_mode: 1'b0,
                hv_mode: 1'b0,
                lv_mode: 1'b0,
                mem_wr_allow: 1'b0,
                lv_enable_clr_grant: 1'b0,
                clear_rst_en: 1'b1,
                core_reset: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs, each straight from the state register
    // ==========================================================
    assign prog_data_pin_o = st_r.data_out;
    assign prog_data_pin_oe_n = st_r.data_oe_n;
    assign rx_bit = st_r.rx_bit;
    assign rx_stb = st_r.rx_stb;
    assign prog_mode = st_r.prog_mode;
    assign hv_mode = st_r.hv_mode;
    assign lv_mode = st_r.lv_mode;
    assign mem_wr_allow = st_r.mem_wr_allow;
    assign lv_enable_clr_grant = st_r.lv_enable_clr_grant;
    assign clear_rst_en = st_r.clear_rst_en;
    assign core_reset = st_r.core_reset;

endmodule

// *** spe_entry_assertions.sv ***
`timescale 1ns/1ps
// ==========================================================
// Checker for the programming entry block
// ==========================================================
module spe_entry_assertions (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Pins and configuration.
    input wire logic prog_clock_pin,
    input wire logic prog_data_pin_o,
    input wire logic prog_data_pin_oe_n,
    input wire logic master_clear_low,
    input wire logic master_clear_hv,
    input wire logic low_voltage_prog_enable,
    input wire logic dev_drive_req,
    // Mode and stream outputs.
    input wire logic rx_stb,
    input wire logic prog_mode,
    input wire logic hv_mode,
    input wire logic lv_mode,
    input wire logic lv_enable_clr_grant,
    input wire logic clear_rst_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // A released master clear must end the session; pins lag by the synchroniser.
    sequence s_lv_drop;
        $fell(master_clear_low) ##0 lv_mode;
    endsequence
    sequence s_hv_drop;
        $fell(master_clear_hv) ##0 hv_mode;
    endsequence
    AST_HV_ENTRY: assert property ($rose(hv_mode) |-> !$past(prog_clock_pin, 3))
        else $error("hv entry with clock high");
    AST_LV_NEED: assert property ($rose(lv_mode) |-> $past(low_voltage_prog_enable))
        else $error("lv entry while disabled");
    AST_LV_EXIT: assert property (s_lv_drop |-> ##[1:8] !prog_mode)
        else $error("lv mode kept");
    AST_HV_EXIT: assert property (s_hv_drop |-> ##[1:8] !prog_mode)
        else $error("hv mode kept");
    AST_RST_EN: assert property (low_voltage_prog_enable |=> clear_rst_en)
        else $error("master clear reset off");
    AST_LVP_CLR: assert property (lv_mode |-> !lv_enable_clr_grant)
        else $error("clear granted in lv mode");
    AST_OE_REQ: assert property (!prog_data_pin_oe_n |-> $past(dev_drive_req))
        else $error("drive without request");
    AST_OE_OFF: assert property (prog_data_pin_oe_n |-> !prog_data_pin_o)
        else $error("data out while released");
    AST_STB: assert property (rx_stb |=> !rx_stb)
        else $error("strobe too long");
endmodule

bind spe_entry spe_entry_assertions i_spe_entry_assertions (.*);

// *** spe_prog.sv ***
`timescale 1ns/1ps
// ==========================================================
// Behavioural programmer on the far side of the pins
// ==========================================================
module spe_prog (
    // Device side of the data wire.
    input wire logic dev_o,
    input wire logic dev_oe_n,
    // Programmer pins.
    output logic pclk,
    output logic data_wire,
    output logic mc_low,
    output logic mc_hv
);
    logic drv_en = 1'b0;
    logic drv_d = 1'b0;
    logic last_d = 1'b0;
    int hp = 32;
    // Nobody driving and no pull: show the inverse so a stale value cannot pass.
    assign data_wire = !dev_oe_n ? dev_o : (drv_en ? drv_d : !last_d);
    always @(data_wire) if (!dev_oe_n || drv_en) last_d = data_wire;
    initial begin
        pclk = 1'b0;
        mc_low = 1'b0;
        mc_hv = 1'b0;
    end
    // One clock period with data held across both edges.
    task automatic clk_bit(input logic b);
        drv_en = 1'b1;
        drv_d = b;
        #(hp / 2);
        pclk = 1'b1;
        #hp;
        pclk = 1'b0;
        #(hp / 2);
    endtask
    // Master clear low first, then the key MSB first.
    task automatic lv_enter(input logic [31:0] k);
        mc_low = 1'b1;
        #100;
        for (int i = 31; i >= 0; i--) clk_bit(k[i]);
        drv_en = 1'b0;
    endtask
    // Clock at the given level, data low, while high voltage is applied.
    task automatic hv_enter(input logic c);
        pclk = c;
        drv_en = 1'b1;
        drv_d = 1'b0;
        #100;
        mc_hv = 1'b1;
        #100;
        pclk = 1'b0;
        drv_en = 1'b0;
    endtask
    task automatic release_all();
        mc_low = 1'b0;
        mc_hv = 1'b0;
        drv_en = 1'b0;
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "spe_defines.svh"
// ==========================================================
// Self-checking bench for the programming entry block
// ==========================================================
module tb;
    logic sys_clk, rst, prog_clock_pin, prog_data_pin_i, prog_data_pin_o;
    logic prog_data_pin_oe_n, master_clear_low, master_clear_hv;
    logic low_voltage_prog_enable, clear_reset_disable_cfg;
    logic dev_drive_req, dev_drive_bit, lv_enable_clear_req, rx_bit, rx_stb, prog_mode;
    logic hv_mode, lv_mode, mem_wr_allow, lv_enable_clr_grant, clear_rst_en, core_reset;
    int miscompares = 0;
    int cmp_count = 0;
    spe_entry i_spe_entry (.*);
    spe_prog i_spe_prog (.dev_o(prog_data_pin_o), .dev_oe_n(prog_data_pin_oe_n),
        .pclk(prog_clock_pin), .data_wire(prog_data_pin_i),
        .mc_low(master_clear_low), .mc_hv(master_clear_hv));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            miscompares++;
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Bounded wait on the mode flag; running out ends the run.
    task automatic wait_prog(input logic v);
        int n;
        n = 0;
        while (prog_mode !== v && n < 500) begin
            cyc(1);
            n++;
        end
        if (n == 500) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic cfg(input logic l, input logic d);
        @(posedge sys_clk);
        low_voltage_prog_enable <= l;
        clear_reset_disable_cfg <= d;
        cyc(3);
    endtask
    // Counts receive strobes over a fixed window of sys_clk cycles.
    task automatic see_stb(output int k);
        k = 0;
        repeat (20) begin
            cyc(1);
            if (rx_stb === 1'b1) k++;
        end
    endtask
    task automatic cmd(input logic r, input logic b, input logic c);
        @(posedge sys_clk);
        dev_drive_req <= r;
        dev_drive_bit <= b;
        lv_enable_clear_req <= c;
        cyc(3);
    endtask
    task automatic leave();
        i_spe_prog.release_all();
        wait_prog(1'b0);
        cyc(10);
        chk(prog_data_pin_oe_n, 1'b1);
    endtask
    // Good key, stream both ways, clear request refused.
    task automatic t_lv_good();
        int k;
        cfg(1'b1, 1'b1);
        chk(clear_rst_en, 1'b1);
        i_spe_prog.lv_enter(`SPE_KEY_VALUE);
        wait_prog(1'b1);
        chk(lv_mode, 1'b1);
        chk(mem_wr_allow, 1'b1);
        chk(core_reset, 1'b0);
        fork
            i_spe_prog.clk_bit(1'b1);
            see_stb(k);
        join
        chk(k == 1, 1'b1);
        chk(rx_bit, 1'b1);
        i_spe_prog.clk_bit(1'b0);
        chk(rx_bit, 1'b0);
        i_spe_prog.drv_en = 1'b0;
        cmd(1'b1, 1'b1, 1'b1);
        chk(prog_data_pin_oe_n, 1'b0);
        chk(prog_data_pin_o, 1'b1);
        chk(lv_enable_clr_grant, 1'b0);
        cmd(1'b0, 1'b0, 1'b0);
        leave();
        $display("test lv_good done");
    endtask
    // Last key bit wrong, slow programmer; then path disabled.
    task automatic t_lv_refused();
        i_spe_prog.hp = 100;
        i_spe_prog.lv_enter(`SPE_KEY_VALUE ^ 32'h0000_0001);
        cyc(40);
        chk(prog_mode, 1'b0);
        chk(core_reset, 1'b1);
        i_spe_prog.hp = 32;
        leave();
        cfg(1'b0, 1'b1);
        chk(clear_rst_en, 1'b0);
        i_spe_prog.lv_enter(`SPE_KEY_VALUE);
        cyc(40);
        chk(prog_mode, 1'b0);
        chk(core_reset, 1'b0);
        leave();
        $display("test lv_refused done");
    endtask
    // High clock refused, then proper entry and clear grant.
    task automatic t_hv();
        i_spe_prog.hv_enter(1'b1);
        cyc(40);
        chk(prog_mode, 1'b0);
        leave();
        i_spe_prog.hv_enter(1'b0);
        wait_prog(1'b1);
        chk(hv_mode, 1'b1);
        cmd(1'b0, 1'b0, 1'b1);
        chk(lv_enable_clr_grant, 1'b1);
        cmd(1'b0, 1'b0, 1'b0);
        leave();
        $display("test hv done");
    endtask
    initial begin
        {rst, low_voltage_prog_enable, clear_reset_disable_cfg} = 3'h4;
        {dev_drive_req, dev_drive_bit, lv_enable_clear_req} = 3'h0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(3);
        chk(prog_data_pin_oe_n, 1'b1);
        t_lv_good();
        t_lv_refused();
        t_hv();
        final_report();
    end
endmodule
